// ==== gpc_host_model.sv ====
// Host-side model: application logic that drives the pads.
// Assumes the bench chooses which pads the host drives and their level.
`timescale 1ns/100ps
`default_nettype none
module gpc_host_model
   import gpc_pkg::*;
(
   // Clock
   input wire logic sys_clk,
   // Host drive control
   input wire logic [GPC_NUM_PADS-1:0] host_en,
   input wire logic [GPC_NUM_PADS-1:0] host_lvl,
   // Device pad side
   input wire logic [GPC_NUM_PADS-1:0] pad_o,
   input wire logic [GPC_NUM_PADS-1:0] pad_oe_n,
   output logic [GPC_NUM_PADS-1:0] pad_wire
);
   logic [GPC_NUM_PADS-1:0] float_q = '0;

   // Undriven lines toggle each cycle, so a stale level never passes
   always @(posedge sys_clk) begin
      float_q <= ~float_q;
   end

   // Device wins where it drives; host may pull low to stop tx
   assign pad_wire = (~pad_oe_n & pad_o) | (pad_oe_n & host_en & host_lvl)
      | (pad_oe_n & ~host_en & float_q);
endmodule
`default_nettype wire

// ==== gpc_pad_cell.sv ====
// One pad cell: role selection and pad drive for a single pad.
// Assumes pad input already synchronised by the caller.
`timescale 1ns/100ps
`default_nettype none
module gpc_pad_cell
   import gpc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Configuration
   input wire gpc_role_t role,
   input wire logic out_level,
   input wire logic alt_out,
   input wire logic alt_drive,
   input wire logic hold_low,
   // Pad side
   input wire logic pad_sync,
   output logic pad_o,
   output logic pad_oe_n,
   // Read back
   output logic read_level
);
   // -----------------------------------------------------------------
   // Drive selection
   // -----------------------------------------------------------------
   // Exactly one role steers the pad at a time; hold_low overrides every role and drives it low
   wire is_out = (role == GPC_ROLE_OUTPUT);
   wire is_alt = (role == GPC_ROLE_ALT);
   wire drive_d = hold_low | is_out | (is_alt & alt_drive);
   wire level_d = hold_low ? 1'b0 : (is_alt ? alt_out : out_level);
   // Output read returns the stored level, input read the pad
   wire read_d = is_out ? out_level : pad_sync;

   // Registered pad drive; enable is low while driving
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pad_o <= 1'b0;
         pad_oe_n <= 1'b0;
         read_level <= 1'b0;
      end else begin
         pad_o <= level_d;
         pad_oe_n <= ~drive_d;
         read_level <= read_d;
      end
   end
endmodule
`default_nettype wire

// ==== gpc_pad_config.sv ====
// Top of the general purpose pad configuration block: seven pads,
// host read/write port, alternate functions from internal firmware.
// Assumes pads arrive asynchronously; firmware signals are on sys_clk.
//
// Summary of operation
// - Each pad is independently an input, an output or an alternate function.
// - Reading an input pad returns the live pad level.
// - Writing an output pad sets its level; reading returns the set level.
// - An alternate-function pad follows firmware, not host reads or writes.
// - Pad four offers transmitter-disable input and voice transmit line.
// - Pad two offers jamming report output and voice receive line.
// - Pad four low in transmitter-control role inhibits the transmitter.
// - Pad five in monitor role is high while transmitting; low after in burst mode, after a hold time in call mode.
`timescale 1ns/100ps
`default_nettype none
module gpc_pad_config
   import gpc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Power on/off transition in progress
   input wire logic power_transition,
   // Host configuration and access port
   input wire logic cfg_we,
   input wire logic [GPC_PAD_SEL_W-1:0] cfg_pad,
   input wire logic [1:0] cfg_role,
   input wire logic cfg_alt_sel,
   input wire logic wr_en,
   input wire logic [GPC_PAD_SEL_W-1:0] wr_pad,
   input wire logic wr_level,
   input wire logic rd_en,
   input wire logic [GPC_PAD_SEL_W-1:0] rd_pad,
   output logic rd_valid,
   output logic rd_level,
   // Firmware alternate function sources
   input wire logic voice_port_word_align,
   input wire logic voice_tx,
   input wire logic jamming_report,
   input wire logic tx_active,
   input wire logic tx_mon_mode,
   input wire logic alarm_buzzer,
   input wire logic network_status_lamp,
   // Firmware alternate function sinks
   output logic voice_rx,
   output logic tx_inhibit,
   // Pads
   input wire logic [GPC_NUM_PADS-1:0] pad_i,
   output logic [GPC_NUM_PADS-1:0] pad_o,
   output logic [GPC_NUM_PADS-1:0] pad_oe_n
);
   // -----------------------------------------------------------------
   // Pad input synchronisers
   // -----------------------------------------------------------------
   logic [GPC_NUM_PADS-1:0] pad_s1_q;
   logic [GPC_NUM_PADS-1:0] pad_s2_q;

   // Two stages; only the second stage is read by logic
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pad_s1_q <= '0;
         pad_s2_q <= '0;
      end else begin
         pad_s1_q <= pad_i;
         pad_s2_q <= pad_s1_q;
      end
   end

   // -----------------------------------------------------------------
   // Configuration state
   // -----------------------------------------------------------------
   gpc_role_t role_q [GPC_NUM_PADS];
   logic [GPC_NUM_PADS-1:0] alt_sel_q;
   logic [GPC_NUM_PADS-1:0] out_q;
   wire gpc_role_t cfg_role_w = (cfg_role == 2'h1) ? GPC_ROLE_OUTPUT :
      (cfg_role == 2'h2) ? GPC_ROLE_ALT : GPC_ROLE_INPUT;

   // -----------------------------------------------------------------
   // Transmit monitor hold counter
   // -----------------------------------------------------------------
   // Call mode keeps the line up for a hold time after the last burst
   logic [GPC_MON_CNT_W-1:0] mon_cnt_q;
   logic mon_q;
   wire mon_hold = (mon_cnt_q != '0);
   wire [GPC_MON_CNT_W-1:0] mon_cnt_d = tx_active ?
      GPC_MON_CNT_W'(GPC_MON_HOLD_CYC) :
      (mon_hold ? mon_cnt_q - 1'b1 : mon_cnt_q);
   wire mon_d = (tx_mon_mode == GPC_MON_BURST) ? tx_active :
      (tx_active | mon_hold);

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         mon_cnt_q <= '0;
         mon_q <= 1'b0;
      end else begin
         mon_cnt_q <= mon_cnt_d;
         mon_q <= mon_d;
      end
   end

   // -----------------------------------------------------------------
   // Alternate function routing per pad
   // -----------------------------------------------------------------
   logic [GPC_NUM_PADS-1:0] alt_out;
   logic [GPC_NUM_PADS-1:0] alt_drive;
   logic [GPC_NUM_PADS-1:0] read_lvl;
   wire hold_low = sys_rst | power_transition;

   // Pad two: sel 0 jam report out, sel 1 voice receive in
   assign alt_out[GPC_PAD_VOICE_ALIGN] = voice_port_word_align;
   assign alt_drive[GPC_PAD_VOICE_ALIGN] = 1'b1;
   assign alt_out[GPC_PAD_JAM] = jamming_report;
   assign alt_drive[GPC_PAD_JAM] = ~alt_sel_q[GPC_PAD_JAM];
   assign alt_out[GPC_PAD_VOICE_TX] = voice_tx;
   assign alt_drive[GPC_PAD_VOICE_TX] = 1'b1;
   // Pad four: sel 0 transmitter disable in, sel 1 voice transmit out
   assign alt_out[GPC_PAD_TX_CTRL] = voice_tx;
   assign alt_drive[GPC_PAD_TX_CTRL] = alt_sel_q[GPC_PAD_TX_CTRL];
   assign alt_out[GPC_PAD_TX_MON] = mon_q;
   assign alt_drive[GPC_PAD_TX_MON] = 1'b1;
   assign alt_out[GPC_PAD_ALARM] = alarm_buzzer;
   assign alt_drive[GPC_PAD_ALARM] = 1'b1;
   assign alt_out[GPC_PAD_LAMP] = network_status_lamp;
   assign alt_drive[GPC_PAD_LAMP] = 1'b1;

   wire tx_ctrl_role = (role_q[GPC_PAD_TX_CTRL] == GPC_ROLE_ALT) &
      ~alt_sel_q[GPC_PAD_TX_CTRL];
   wire inhibit_d = tx_ctrl_role & ~pad_s2_q[GPC_PAD_TX_CTRL];
   wire rx_role = (role_q[GPC_PAD_JAM] == GPC_ROLE_ALT) &
      alt_sel_q[GPC_PAD_JAM];
   wire voice_rx_d = rx_role & pad_s2_q[GPC_PAD_JAM];

   // -----------------------------------------------------------------
   // Per pad state and cells
   // -----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < GPC_NUM_PADS; g++) begin : g_pad
         wire cfg_hit = cfg_we & (cfg_pad == GPC_PAD_SEL_W'(g));
         // Host writes are ignored unless the pad is an output
         wire wr_hit = wr_en & (wr_pad == GPC_PAD_SEL_W'(g)) &
            (role_q[g] == GPC_ROLE_OUTPUT);

         always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
               role_q[g] <= GPC_ROLE_INPUT;
               alt_sel_q[g] <= GPC_ALT_SEL_RESET;
               out_q[g] <= GPC_OUT_RESET;
            end else begin
               if (cfg_hit) begin
                  role_q[g] <= cfg_role_w;
                  alt_sel_q[g] <= cfg_alt_sel;
               end
               if (wr_hit) begin
                  out_q[g] <= wr_level;
               end
            end
         end

         gpc_pad_cell u_cell (
            .sys_clk(sys_clk),
            .sys_rst(sys_rst),
            .role(role_q[g]),
            .out_level(out_q[g]),
            .alt_out(alt_out[g]),
            .alt_drive(alt_drive[g]),
            .hold_low(hold_low),
            .pad_sync(pad_s2_q[g]),
            .pad_o(pad_o[g]),
            .pad_oe_n(pad_oe_n[g]),
            .read_level(read_lvl[g])
         );
      end
   endgenerate

   // -----------------------------------------------------------------
   // Host read port and firmware sinks
   // -----------------------------------------------------------------
   wire rd_ok = (rd_pad < GPC_PAD_SEL_W'(GPC_NUM_PADS));
   wire rd_lvl_d = rd_ok ? read_lvl[rd_pad] : 1'b0;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rd_valid <= 1'b0;
         rd_level <= 1'b0;
         tx_inhibit <= 1'b0;
         voice_rx <= 1'b0;
      end else begin
         rd_valid <= rd_en;
         rd_level <= rd_lvl_d;
         tx_inhibit <= inhibit_d;
         voice_rx <= voice_rx_d;
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   property p_rst_default;
      @(posedge sys_clk) sys_rst |=> (role_q[0] == GPC_ROLE_INPUT) &&
         (pad_o == '0);
   endproperty
   a_rst_default: assert property (p_rst_default)
      else $error("pads not defaulted by reset");

   property p_hold_low;
      @(posedge sys_clk) disable iff (sys_rst)
         power_transition |=> (pad_o == '0) && (pad_oe_n == '0);
   endproperty
   a_hold_low: assert property (p_hold_low)
      else $error("pads not held low in power transition");

   property p_out_write;
      @(posedge sys_clk) disable iff (sys_rst)
         (wr_en && wr_pad == 3'h2 && role_q[2] == GPC_ROLE_OUTPUT &&
          !cfg_we && !power_transition) ##1 !power_transition
         |=> pad_o[2] == $past(wr_level, 2);
   endproperty
   a_out_write: assert property (p_out_write)
      else $error("output pad did not take written level");

   property p_alt_ignores_write;
      @(posedge sys_clk) disable iff (sys_rst)
         (role_q[1] == GPC_ROLE_ALT && !cfg_we) |=> $stable(out_q[1]);
   endproperty
   a_alt_ignores_write: assert property (p_alt_ignores_write)
      else $error("alternate pad took a host write");

   property p_inhibit;
      @(posedge sys_clk) disable iff (sys_rst)
         (tx_ctrl_role && !pad_s2_q[GPC_PAD_TX_CTRL]) |=> tx_inhibit;
   endproperty
   a_inhibit: assert property (p_inhibit)
      else $error("transmitter not inhibited");

   property p_mon_high;
      @(posedge sys_clk) disable iff (sys_rst)
         tx_active |=> mon_q;
   endproperty
   a_mon_high: assert property (p_mon_high)
      else $error("monitor low while transmitting");

   // Burst mode must ignore any hold time left from an earlier call
   property p_mon_burst_low;
      @(posedge sys_clk) disable iff (sys_rst)
         (tx_mon_mode == GPC_MON_BURST && !tx_active) |=> !mon_q;
   endproperty
   a_mon_burst_low: assert property (p_mon_burst_low)
      else $error("monitor high after burst ended");

   property p_rd_input;
      @(posedge sys_clk) disable iff (sys_rst)
         (rd_en && rd_pad == 3'h0 && role_q[0] == GPC_ROLE_INPUT &&
          $past(role_q[0]) == GPC_ROLE_INPUT)
         |=> rd_level == $past(pad_s2_q[0], 2);
   endproperty
   a_rd_input: assert property (p_rd_input)
      else $error("input read did not return pad level");

   property p_one_role;
      @(posedge sys_clk) disable iff (sys_rst)
         (role_q[3] == GPC_ROLE_INPUT && !power_transition) ##1
         (role_q[3] == GPC_ROLE_INPUT && !power_transition)
         |=> pad_oe_n[3];
   endproperty
   a_one_role: assert property (p_one_role)
      else $error("input pad is being driven");

   property p_voice_rx;
      @(posedge sys_clk) disable iff (sys_rst)
         !rx_role |=> !voice_rx;
   endproperty
   a_voice_rx: assert property (p_voice_rx)
      else $error("voice receive active outside its role");
endmodule
`default_nettype wire

// ==== gpc_pkg.sv ====
// Package for the general purpose pad configuration block.
// Assumes a single 25 MHz system clock and synchronous reset.
package gpc_pkg;
   // -----------------------------------------------------------------
   // Pad counts and roles
   // -----------------------------------------------------------------
   localparam int GPC_NUM_PADS = 7;
   localparam int GPC_PAD_SEL_W = 3;
   // Pad indices (zero based) of pads with special functions
   localparam int GPC_PAD_VOICE_ALIGN = 0;
   localparam int GPC_PAD_JAM = 1;
   localparam int GPC_PAD_VOICE_TX = 2;
   localparam int GPC_PAD_TX_CTRL = 3;
   localparam int GPC_PAD_TX_MON = 4;
   localparam int GPC_PAD_ALARM = 5;
   localparam int GPC_PAD_LAMP = 6;

   // Role encoding as held per pad
   typedef enum logic [1:0] {
      GPC_ROLE_INPUT,
      GPC_ROLE_OUTPUT,
      GPC_ROLE_ALT
   } gpc_role_t;

   // Alternate function selector for pads offering two functions
   localparam logic GPC_ALT_SEL_RESET = 1'b0;
   localparam logic GPC_OUT_RESET = 1'b0;

   // Transmit monitor modes
   localparam logic GPC_MON_CALL = 1'b0;
   localparam logic GPC_MON_BURST = 1'b1;

   // -----------------------------------------------------------------
   // Transmit monitor timing
   // -----------------------------------------------------------------
   localparam int GPC_CLK_HZ = 25000000;
   localparam int GPC_MON_HOLD_MS = 500;
   localparam int GPC_MON_HOLD_CYC = GPC_MON_HOLD_MS * (GPC_CLK_HZ / 1000);
   localparam int GPC_MON_CNT_W = 24;
endpackage

// ==== tb_gpc_pad_config.sv ====
// Testbench for the pad configuration block with a host pad model.
// Assumes a 25 MHz clock and outputs registered one edge behind inputs.
`timescale 1ns/100ps
`default_nettype none
module tb_gpc_pad_config;
   import gpc_pkg::*;
   // ------------------------------------------------------------
   // Stimulus and observed signals
   // ------------------------------------------------------------
   logic sys_clk = 1'b0, sys_rst = 1'b1, power_transition = 1'b0;
   logic cfg_we = 1'b0, cfg_alt_sel = 1'b0, wr_en = 1'b0, wr_level = 1'b0;
   logic [2:0] cfg_pad = 3'h0, wr_pad = 3'h0, rd_pad = 3'h0;
   logic [1:0] cfg_role = 2'h0;
   logic rd_en = 1'b0, voice_port_word_align = 1'b0, voice_tx = 1'b0;
   logic jamming_report = 1'b0, tx_active = 1'b0, tx_mon_mode = 1'b0;
   logic alarm_buzzer = 1'b0, network_status_lamp = 1'b0;
   logic rd_valid, rd_level, voice_rx, tx_inhibit;
   logic [6:0] pad_o, pad_oe_n, pad_wire;
   logic [6:0] host_en = 7'h00, host_lvl = 7'h00;
   int n_errors = 0, n_checks = 0;

   always #20 sys_clk = ~sys_clk;

   gpc_pad_config u_dut (.sys_clk, .sys_rst, .power_transition, .cfg_we,
      .cfg_pad, .cfg_role, .cfg_alt_sel, .wr_en, .wr_pad, .wr_level, .rd_en,
      .rd_pad, .rd_valid, .rd_level, .voice_port_word_align, .voice_tx,
      .jamming_report, .tx_active, .tx_mon_mode, .alarm_buzzer,
      .network_status_lamp, .voice_rx, .tx_inhibit, .pad_i(pad_wire),
      .pad_o, .pad_oe_n);
   gpc_host_model u_host (.sys_clk, .host_en, .host_lvl, .pad_o, .pad_oe_n,
      .pad_wire);

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [6:0] seen,
      input logic [6:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Wait edges, then step past them so outputs have settled
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic cfg(input int p, input logic [1:0] r, input logic s);
      @(posedge sys_clk);
      cfg_we <= 1'b1;
      cfg_pad <= p[2:0];
      cfg_role <= r;
      cfg_alt_sel <= s;
      @(posedge sys_clk);
      cfg_we <= 1'b0;
   endtask
   task automatic wr(input int p, input logic l);
      @(posedge sys_clk);
      wr_en <= 1'b1;
      wr_pad <= p[2:0];
      wr_level <= l;
      @(posedge sys_clk);
      wr_en <= 1'b0;
   endtask
   // The answer stands one cycle only, so it is looked at then
   task automatic rd(input int p, input logic exp);
      @(posedge sys_clk);
      rd_en <= 1'b1;
      rd_pad <= p[2:0];
      @(posedge sys_clk);
      rd_en <= 1'b0;
      #1;
      chk("rd_valid", 7'(rd_valid), 7'h01);
      chk("rd_level", 7'(rd_level), 7'(exp));
   endtask
   task automatic host(input int p, input logic lvl);
      @(posedge sys_clk);
      host_en[p] <= 1'b1;
      host_lvl[p] <= lvl;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      cyc(3);
      chk("rst oe_n", pad_oe_n, 7'h00);
      chk("rst pad_o", pad_o, 7'h00);
      repeat (5) @(posedge sys_clk);
      sys_rst <= 1'b0;
      cyc(2);
      chk("default oe_n", pad_oe_n, 7'h7F);
   endtask
   task automatic t_io;
      host(0, 1'b1);
      cyc(5);
      rd(0, 1'b1);
      host(0, 1'b0);
      cyc(5);
      rd(0, 1'b0);
      wr(2, 1'b1);
      cfg(2, 2'h1, 1'b0);
      cyc(3);
      chk("out oe_n", pad_oe_n, 7'h7B);
      chk("dropped wr", 7'(pad_o[2]), 7'h00);
      wr(2, 1'b1);
      cyc(3);
      chk("out level", 7'(pad_o[2]), 7'h01);
      rd(2, 1'b1);
   endtask
   task automatic t_pad_two;
      cfg(1, 2'h2, 1'b0);
      jamming_report <= 1'b1;
      cyc(3);
      chk("jam", {pad_oe_n[1], pad_o[1]}, 7'h01);
      // Write a level opposite to the source so a leak would show
      wr(1, 1'b1);
      jamming_report <= 1'b0;
      cyc(3);
      chk("jam vs wr", 7'(pad_o[1]), 7'h00);
      cfg(1, 2'h2, 1'b1);
      host(1, 1'b1);
      cyc(6);
      chk("voice rx", {pad_oe_n[1], voice_rx}, 7'h03);
      host(1, 1'b0);
      cyc(6);
      chk("voice rx", 7'(voice_rx), 7'h00);
   endtask
   task automatic t_pad_four;
      cfg(3, 2'h2, 1'b0);
      host(3, 1'b0);
      cyc(6);
      chk("inhibit", {pad_oe_n[3], tx_inhibit}, 7'h03);
      host(3, 1'b1);
      cyc(6);
      chk("inhibit", 7'(tx_inhibit), 7'h00);
      host(3, 1'b0);
      cfg(3, 2'h2, 1'b1);
      voice_tx <= 1'b1;
      cyc(6);
      chk("voice tx", {tx_inhibit, pad_oe_n[3], pad_o[3]}, 7'h01);
   endtask
   task automatic t_monitor;
      // Call mode first: the hold counter is still clear from reset
      cfg(4, 2'h2, 1'b0);
      cyc(3);
      chk("mon idle", 7'(pad_o[4]), 7'h00);
      @(posedge sys_clk);
      tx_active <= 1'b1;
      cyc(3);
      @(posedge sys_clk);
      tx_active <= 1'b0;
      cyc(3);
      chk("mon call", 7'(pad_o[4]), 7'h01);
      @(posedge sys_clk);
      tx_mon_mode <= GPC_MON_BURST;
      tx_active <= 1'b1;
      cyc(3);
      chk("mon burst", 7'(pad_o[4]), 7'h01);
      @(posedge sys_clk);
      tx_active <= 1'b0;
      cyc(3);
      chk("mon burst", 7'(pad_o[4]), 7'h00);
   endtask
   task automatic t_alt_rest;
      cfg(0, 2'h2, 1'b0);
      cfg(5, 2'h2, 1'b0);
      cfg(6, 2'h2, 1'b0);
      voice_port_word_align <= 1'b1;
      network_status_lamp <= 1'b1;
      cyc(3);
      chk("alt src", {pad_o[6], pad_o[5], pad_o[0]}, 7'h05);
      @(posedge sys_clk);
      voice_port_word_align <= 1'b0;
      alarm_buzzer <= 1'b1;
      network_status_lamp <= 1'b0;
      cyc(3);
      chk("alt src", {pad_o[6], pad_o[5], pad_o[0]}, 7'h02);
   endtask
   task automatic t_power;
      @(posedge sys_clk);
      power_transition <= 1'b1;
      cyc(3);
      chk("pwr oe_n", pad_oe_n, 7'h00);
      chk("pwr pad_o", pad_o, 7'h00);
      @(posedge sys_clk);
      power_transition <= 1'b0;
      cyc(2);
      chk("pwr end", 7'(pad_o[2]), 7'h01);
   endtask

   // ------------------------------------------------------------
   // Sequence, watchdog and verdict
   // ------------------------------------------------------------
   task automatic give_verdict;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Whole run is about 130 cycles; this allows 5000, over thirty times that
   initial begin
      #200000;
      n_errors++;
      give_verdict();
   end
   initial begin
      t_reset();
      t_io();
      t_pad_two();
      t_pad_four();
      t_monitor();
      t_alt_rest();
      t_power();
      give_verdict();
   end
endmodule
`default_nettype wire
